// >>> verilog/cotl_trigger.sv
`timescale 1ns/1ns
// Functional notes
// - send-on-trigger: one queued frame per rising edge
// - empty queue: resend last frame per edge
// - stamp mode: capture edge time into read queue
// - stamp frame carries pattern, high byte first
// - receive output: pulse per queued received frame
// - transmit output: pulse per successful send
// - command output: pulse on software action
// - line index limited to zero through six
// - pulse output held at least 100 ns
// - toggle output inverts level per event
// - input modes always detect rising edges
// - input modes skip N edges, act on N+1
// - disabled: plain message object behaviour
// - object bound to one 11 or 29-bit identifier
// - unsolicited receive queues matching data frames, except in send-on-trigger or in a stamp cycle
module cotl_trigger
    import cotl_pkg::*;
#(
    parameter int SKIP_W = 16
) (
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    input  wire logic [2:0]            trigger_function_select,
    input  wire logic [2:0]            comm_type,
    input  wire logic [2:0]            trigger_line_index,
    input  wire logic                  output_shape_select,
    input  wire logic [SKIP_W-1:0]     edge_skip_count,
    input  wire logic [31:0]           timestamp_user_pattern,
    input  wire logic                  extended_identifier,
    input  wire logic [ID_W-1:0]       object_id,
    input  wire logic [3:0]            object_length,
    input  wire logic                  period_tick,
    input  wire logic [TS_W-1:0]       timebase,
    input  wire logic                  object_write_call,
    input  wire logic [DATA_W-1:0]     object_write_data,
    output logic                       write_ready,
    output logic                       tx_req,
    output logic [FRAME_W-1:0]         tx_frame,
    input  wire logic                  tx_done,
    input  wire logic                  rx_valid,
    input  wire logic                  rx_extended,
    input  wire logic [ID_W-1:0]       rx_id,
    input  wire logic                  rx_remote,
    input  wire logic [3:0]            rx_length,
    input  wire logic [DATA_W-1:0]     rx_data,
    output logic                       rq_valid,
    output logic [FRAME_W-1:0]         rq_frame,
    output logic [TS_W-1:0]            rq_stamp,
    output logic                       rq_is_stamp,
    input  wire logic                  object_read_call,
    input  wire logic                  object_action_call,
    output logic                       config_error,
    input  wire logic [LINE_COUNT-1:0] trig_in,
    output logic [LINE_COUNT-1:0]      trig_out,
    output logic [LINE_COUNT-1:0]      trig_oe
);
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_BUSY = 2'b01
    } cotl_tx_state_type;

    typedef struct packed {
        logic [LINE_COUNT-1:0] s1, s2, s3;
        logic                  lvl;
        logic [SKIP_W-1:0]     skip;
        cotl_tx_state_type     txs;
        logic                  have_last;
        logic [DATA_W-1:0]     last;
        logic                  tx_req;
        logic [FRAME_W-1:0]    tx_frame;
        logic                  rq_valid;
        logic [FRAME_W-1:0]    rq_frame;
        logic [TS_W-1:0]       rq_stamp;
        logic                  rq_is_stamp;
        logic [LINE_COUNT-1:0] out;
        logic [LINE_COUNT-1:0] oe;
        logic [1:0]            pcnt;
        logic                  cfg_err;
    } cotl_state_type;

    cotl_state_type st_q, st_d;
    logic [2:0]     line;
    logic           sel_in, rise, act, in_mode, out_mode, tx_type, id_hit, recv_ok;
    logic           rx_store, stamp_store, out_event;
    logic           wq_valid, wq_ready;
    logic [DATA_W-1:0] wq_data;

    // write queue of outgoing data frames
    cotl_fifo_if #(.W(DATA_W)) wq ();
    assign wq.in_valid  = object_write_call;
    assign wq.in_data   = object_write_data;
    assign write_ready  = wq.in_ready;
    assign wq_valid     = wq.out_valid;
    assign wq_data      = wq.out_data;
    assign wq.out_ready = wq_ready;
    cotl_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_wq (
        .mclk (mclk),
        .nrst (nrst),
        .f    (wq)
    );

    // mode decode and line selection
    assign line     = (trigger_line_index > LINE_MAX) ? LINE_MAX : trigger_line_index;
    assign in_mode  = trigger_function_select == FUNC_IN_SEND ||
                      trigger_function_select == FUNC_IN_STAMP;
    assign out_mode = trigger_function_select == FUNC_OUT_RECV ||
                      trigger_function_select == FUNC_OUT_SENT ||
                      trigger_function_select == FUNC_OUT_CMD;
    assign tx_type  = comm_type == COMM_TX_CALL || comm_type == COMM_TX_PERIOD ||
                      comm_type == COMM_TX_WAVE;

    // synchronised level of the selected line, edge once stages two and three agree
    assign sel_in = (st_q.s2[line] == st_q.s3[line]) ? st_q.s3[line] : st_q.lvl;
    assign rise   = in_mode && sel_in && !st_q.lvl;
    assign act    = rise && st_q.skip == edge_skip_count;

    // identifier match, standard ids compare low bits only
    assign id_hit = (rx_extended == extended_identifier) &&
                    (extended_identifier ? rx_id == object_id
                     : rx_id[STD_ID_W-1:0] == object_id[STD_ID_W-1:0]);
    assign recv_ok = comm_type == COMM_RECV_UNSOL &&
                     (trigger_function_select != FUNC_IN_SEND);
    assign rx_store    = rx_valid && !rx_remote && id_hit && recv_ok;
    assign stamp_store = act && trigger_function_select == FUNC_IN_STAMP;

    // output event sources per mode
    always_comb begin
        case (trigger_function_select)
            FUNC_OUT_RECV: out_event = rx_store && comm_type == COMM_RECV_UNSOL;
            FUNC_OUT_SENT: out_event = tx_done && st_q.txs == TX_BUSY && tx_type;
            FUNC_OUT_CMD:  out_event = object_action_call;
            default:       out_event = 1'b0;
        endcase
    end

    // next-state logic
    always_comb begin
        st_d        = st_q;
        wq_ready    = 1'b0;
        // every line synchronised, so a line switch sees settled history
        st_d.s1     = trig_in;
        st_d.s2     = st_q.s1;
        st_d.s3     = st_q.s2;
        st_d.lvl    = sel_in;
        st_d.rq_valid = st_q.rq_valid && !object_read_call;
        // skip counter runs only in input modes
        if (!in_mode) begin
            st_d.skip = '0;
        end else if (rise) begin
            st_d.skip = act ? '0 : st_q.skip + 1'b1;
        end
        // transmit path
        case (st_q.txs)
            TX_IDLE: begin
                if (trigger_function_select == FUNC_IN_SEND) begin
                    if (act && tx_type) begin
                        if (wq_valid) begin
                            wq_ready       = 1'b1;
                            st_d.last      = wq_data;
                            st_d.have_last = 1'b1;
                            st_d.tx_frame  = {extended_identifier, object_id,
                                              object_length, wq_data};
                            st_d.tx_req    = 1'b1;
                            st_d.txs       = TX_BUSY;
                        end else if (st_q.have_last) begin
                            st_d.tx_frame  = {extended_identifier, object_id,
                                              object_length, st_q.last};
                            st_d.tx_req    = 1'b1;
                            st_d.txs       = TX_BUSY;
                        end
                    end
                end else if (tx_type && wq_valid &&
                             (comm_type == COMM_TX_CALL || period_tick)) begin
                    wq_ready       = 1'b1;
                    st_d.last      = wq_data;
                    st_d.have_last = 1'b1;
                    st_d.tx_frame  = {extended_identifier, object_id, object_length, wq_data};
                    st_d.tx_req    = 1'b1;
                    st_d.txs       = TX_BUSY;
                end else if (comm_type == COMM_TX_PERIOD && period_tick && st_q.have_last) begin
                    st_d.tx_frame  = {extended_identifier, object_id, object_length, st_q.last};
                    st_d.tx_req    = 1'b1;
                    st_d.txs       = TX_BUSY;
                end
            end
            TX_BUSY: begin
                if (tx_done) begin
                    st_d.tx_req = 1'b0;
                    st_d.txs    = TX_IDLE;
                end
            end
            default: st_d.txs = TX_IDLE;
        endcase
        // read queue word, stamp wins over a data frame in the same cycle
        if (stamp_store) begin
            st_d.rq_valid    = 1'b1;
            st_d.rq_is_stamp = 1'b1;
            st_d.rq_stamp    = timebase;
            st_d.rq_frame    = {extended_identifier, object_id, STAMP_LEN,
                                timestamp_user_pattern, 32'h0};
        end else if (rx_store) begin
            st_d.rq_valid    = 1'b1;
            st_d.rq_is_stamp = 1'b0;
            st_d.rq_stamp    = timebase;
            st_d.rq_frame    = {rx_extended, rx_id, rx_length, rx_data};
        end
        // trigger output drive
        st_d.oe = '0;
        if (out_mode) begin
            st_d.oe[line] = 1'b1;
        end else begin
            st_d.out  = '0;
            st_d.pcnt = '0;
        end
        if (out_mode && output_shape_select == SHAPE_TOGGLE) begin
            if (out_event) st_d.out[line] = !st_q.out[line];
        end else if (out_mode) begin
            if (out_event) begin
                st_d.out       = '0;
                st_d.out[line] = 1'b1;
                st_d.pcnt      = 2'(PULSE_CYC);
            end else if (st_q.pcnt > 2'h1) begin
                st_d.pcnt = st_q.pcnt - 1'b1;
            end else begin
                st_d.pcnt = '0;
                st_d.out  = '0;
            end
        end
        st_d.cfg_err = (trigger_function_select == FUNC_IN_SEND && !tx_type) ||
                       (trigger_function_select == FUNC_OUT_RECV &&
                        comm_type != COMM_RECV_UNSOL) ||
                       (trigger_function_select == FUNC_OUT_SENT && !tx_type) ||
                       trigger_line_index > LINE_MAX;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from state
    assign tx_req       = st_q.tx_req;
    assign tx_frame     = st_q.tx_frame;
    assign rq_valid     = st_q.rq_valid;
    assign rq_frame     = st_q.rq_frame;
    assign rq_stamp     = st_q.rq_stamp;
    assign rq_is_stamp  = st_q.rq_is_stamp;
    assign trig_out     = st_q.out;
    assign trig_oe      = st_q.oe;
    assign config_error = st_q.cfg_err;

    // assertions
    property p_pulse_width;
        @(posedge mclk) disable iff (!nrst)
        $rose(trig_out[line]) && output_shape_select == SHAPE_PULSE &&
        $stable(trigger_function_select) |-> trig_out[line] [*2];
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse too short");

    property p_toggle;
        @(posedge mclk) disable iff (!nrst)
        out_mode && output_shape_select == SHAPE_TOGGLE && out_event && $stable(line)
        |=> trig_out[$past(line)] != $past(trig_out[line]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_stamp_pattern;
        @(posedge mclk) disable iff (!nrst)
        stamp_store |=> rq_valid && rq_is_stamp &&
        rq_frame[DATA_W-1 -: 8] == $past(timestamp_user_pattern[31:24]);
    endproperty
    a_stamp_pattern: assert property (p_stamp_pattern) else $error("stamp byte order");

    property p_send_on_edge;
        @(posedge mclk) disable iff (!nrst)
        st_q.txs == TX_IDLE && act && trigger_function_select == FUNC_IN_SEND && tx_type &&
        (wq_valid || st_q.have_last) |=> tx_req;
    endproperty
    a_send_on_edge: assert property (p_send_on_edge) else $error("no send on edge");

    property p_resend;
        @(posedge mclk) disable iff (!nrst)
        st_q.txs == TX_IDLE && act && trigger_function_select == FUNC_IN_SEND && tx_type &&
        !wq_valid && st_q.have_last |=> tx_frame[DATA_W-1:0] == $past(st_q.last);
    endproperty
    a_resend: assert property (p_resend) else $error("last frame not resent");

    property p_skip;
        @(posedge mclk) disable iff (!nrst)
        rise && st_q.skip != edge_skip_count |->
        !stamp_store && !(wq_ready && trigger_function_select == FUNC_IN_SEND);
    endproperty
    a_skip: assert property (p_skip) else $error("skipped edge acted on");

    property p_line_range;
        @(posedge mclk) disable iff (!nrst) trig_oe[LINE_COUNT-1:LINE_COUNT-1] == 1'b0 ||
        trigger_line_index >= LINE_MAX || $past(trigger_line_index) >= LINE_MAX;
    endproperty
    a_line_range: assert property (p_line_range) else $error("line out of range");

    property p_disabled_quiet;
        @(posedge mclk) disable iff (!nrst)
        trigger_function_select == FUNC_DISABLED [*2] |-> trig_oe == '0 && !stamp_store;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled mode active");

    property p_rx_queue;
        @(posedge mclk) disable iff (!nrst)
        rx_store && !stamp_store |=> rq_valid && !rq_is_stamp;
    endproperty
    a_rx_queue: assert property (p_rx_queue) else $error("matching frame not queued");

    // input modes never drive, command pulse follows the action
    property p_input_quiet;
        @(posedge mclk) disable iff (!nrst)
        in_mode |=> trig_oe == '0;
    endproperty
    a_input_quiet: assert property (p_input_quiet) else $error("input mode drives line");

    property p_cmd_pulse;
        @(posedge mclk) disable iff (!nrst)
        out_mode && object_action_call && trigger_function_select == FUNC_OUT_CMD &&
        output_shape_select == SHAPE_PULSE |=> trig_out[$past(line)];
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse missing");

    // main scenarios reached
    c_stamp:  cover property (@(posedge mclk) disable iff (!nrst) stamp_store);
    c_rx:     cover property (@(posedge mclk) disable iff (!nrst) rx_store && out_mode);
    c_toggle: cover property (@(posedge mclk) disable iff (!nrst)
        out_event && output_shape_select == SHAPE_TOGGLE);
    c_resend: cover property (@(posedge mclk) disable iff (!nrst)
        act && !wq_valid && st_q.have_last);
    c_pulse:  cover property (@(posedge mclk) disable iff (!nrst) $rose(trig_out[line]));
endmodule : cotl_trigger

// >>> verilog/cotl_pkg.sv
package cotl_pkg;
    // trigger function select encodings
    localparam logic [2:0] FUNC_DISABLED   = 3'h0;
    localparam logic [2:0] FUNC_IN_SEND    = 3'h1;
    localparam logic [2:0] FUNC_IN_STAMP   = 3'h2;
    localparam logic [2:0] FUNC_OUT_RECV   = 3'h3;
    localparam logic [2:0] FUNC_OUT_SENT   = 3'h4;
    localparam logic [2:0] FUNC_OUT_CMD    = 3'h5;
    // communication type encodings
    localparam logic [2:0] COMM_RECV_UNSOL = 3'h0;
    localparam logic [2:0] COMM_TX_CALL    = 3'h1;
    localparam logic [2:0] COMM_TX_PERIOD  = 3'h2;
    localparam logic [2:0] COMM_TX_WAVE    = 3'h3;
    // output shapes
    localparam logic       SHAPE_PULSE     = 1'b0;
    localparam logic       SHAPE_TOGGLE    = 1'b1;
    // line index range and widths
    localparam int         LINE_COUNT      = 7;
    localparam logic [2:0] LINE_MAX        = 3'h6;
    localparam int         ID_W            = 29;
    localparam int         STD_ID_W        = 11;
    localparam int         DATA_W          = 64;
    localparam int         TS_W            = 32;
    localparam int         FIFO_DEPTH      = 16;
    // frame word: extended flag, identifier, length, data
    localparam int         FRAME_W         = 1 + ID_W + 4 + DATA_W;
    localparam logic [3:0] STAMP_LEN       = 4'h4;
    // timing
    localparam int         CLK_PERIOD_NS   = 50;
    localparam int         PULSE_MIN_NS    = 100;
    localparam int         PULSE_CYC       = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset values
    localparam logic [DATA_W-1:0] DATA_RST = 64'h0;
    localparam logic [TS_W-1:0]   TS_RST   = 32'h0;
endpackage : cotl_pkg

// >>> verilog/cotl_fifo_if.sv
`timescale 1ns/1ns
interface cotl_fifo_if #(parameter int W = 8);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : cotl_fifo_if

// >>> verilog/cotl_fifo.sv
`timescale 1ns/1ns
module cotl_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic mclk,
    input  wire logic nrst,
    cotl_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } cotl_fifo_st_type;
    cotl_fifo_st_type st_q, st_d;
    logic [W-1:0] mem [DEPTH];
    logic         push, pop;

    // handshakes and flags
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;
    assign f.in_ready  = st_q.cnt != (AW+1)'(DEPTH);
    assign f.out_valid = st_q.cnt != '0;
    assign f.out_data  = mem[st_q.rd];

    // pointer update
    always_comb begin
        st_d = st_q;
        if (push) st_d.wr = st_q.wr + 1'b1;
        if (pop)  st_d.rd = st_q.rd + 1'b1;
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) st_q <= '0;
        else       st_q <= st_d;
    end

    // storage
    always_ff @(posedge mclk) begin
        if (push) mem[st_q.wr] <= f.in_data;
    end

    property p_no_overflow;
        @(posedge mclk) disable iff (!nrst) st_q.cnt <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo count beyond depth");
endmodule : cotl_fifo

// >>> verif/cotl_line_partner.sv
`timescale 1ns/1ns
// far side: other boards on the trigger lines, network done answer
module cotl_line_partner
    import cotl_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    input  wire logic [LINE_COUNT-1:0] trig_out,
    input  wire logic [LINE_COUNT-1:0] trig_oe,
    input  wire logic [LINE_COUNT-1:0] ext_lvl,
    input  wire logic                  slow,
    input  wire logic                  tx_req,
    output logic      [LINE_COUNT-1:0] trig_in,
    output logic                       tx_done
);
    logic [2:0] wait_q;
    // wired lines: the driving board wins, else the other boards' level
    assign trig_in = (trig_oe & trig_out) | (~trig_oe & ext_lvl);
    // done pulse after a prompt or slow wait, off the sampling edge
    always @(negedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_q  <= 3'h0;
            tx_done <= 1'b0;
        end else if (tx_req === 1'b1 && !tx_done) begin
            if (wait_q == (slow ? 3'h6 : 3'h1)) begin
                tx_done <= 1'b1;
                wait_q  <= 3'h0;
            end else begin
                wait_q <= wait_q + 3'h1;
            end
        end else begin
            tx_done <= 1'b0;
        end
    end
endmodule : cotl_line_partner

// >>> verif/can_object_trigger_line_logic_bench.sv
`timescale 1ns/1ns
module can_object_trigger_line_logic_bench
    import cotl_pkg::*;
;
    typedef struct packed {
        logic [2:0] func;
        logic [2:0] comm;
        logic       shape;
        logic [2:0] line;
        logic [2:0] ev;
        logic [1:0] chg;
    } cotl_row_type;
    logic                  mclk, nrst, extended_identifier, output_shape_select, prev;
    logic                  period_tick, object_write_call, tx_done, rx_valid, slow, rx_remote;
    logic                  object_read_call, object_action_call, write_ready;
    logic                  tx_req, rq_valid, rq_is_stamp, config_error;
    logic [2:0]            trigger_function_select, comm_type, trigger_line_index;
    logic [15:0]           edge_skip_count;
    logic [31:0]           timestamp_user_pattern;
    logic [ID_W-1:0]       object_id, rx_id;
    logic [3:0]            object_length;
    logic [TS_W-1:0]       timebase, rq_stamp, t_rise;
    logic [DATA_W-1:0]     object_write_data;
    logic [FRAME_W-1:0]    tx_frame, rq_frame;
    logic [LINE_COUNT-1:0] trig_in, trig_out, trig_oe, ext_lvl;
    logic [FRAME_W-1:0]    sent_q[$];
    int                    err_total, check_count, changes, width, run, n;
    cotl_row_type          rows [6];

    cotl_line_partner peer (.mclk, .nrst, .trig_out, .trig_oe, .ext_lvl, .slow, .tx_req,
        .trig_in, .tx_done);
    cotl_trigger dut (.mclk, .nrst, .trigger_function_select, .comm_type,
        .trigger_line_index, .output_shape_select, .edge_skip_count,
        .timestamp_user_pattern, .extended_identifier, .object_id, .object_length,
        .period_tick, .timebase, .object_write_call, .object_write_data, .write_ready,
        .tx_req, .tx_frame, .tx_done, .rx_valid, .rx_extended(extended_identifier), .rx_id,
        .rx_remote, .rx_length(object_length), .rx_data(object_write_data),
        .rq_valid, .rq_frame, .rq_stamp, .rq_is_stamp, .object_read_call,
        .object_action_call, .config_error, .trig_in, .trig_out, .trig_oe);

    // clock, free running time base, record of accepted sends
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(negedge mclk) timebase <= timebase + 32'h1;
    always @(posedge mclk) if (tx_req === 1'b1 && tx_done === 1'b1) sent_q.push_back(tx_frame);
    // selected line: level changes and length of the last high run
    always @(posedge mclk) begin
        if (trig_out[trigger_line_index] !== prev) changes++;
        if (trig_out[trigger_line_index] === 1'b1) run++;
        else if (run != 0) begin
            width = run;
            run = 0;
        end
        prev = trig_out[trigger_line_index];
    end

    task automatic check(input string what, input logic [FRAME_W-1:0] exp,
                         input logic [FRAME_W-1:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic cycles(input int k);
        repeat (k) @(negedge mclk);
    endtask : cycles

    // one-cycle strobe: 0 rx, 1 write, 2 read, 3 action, 4 period
    task automatic strobe(input int k);
        @(negedge mclk);
        {rx_valid, object_write_call, object_read_call, object_action_call, period_tick} =
            5'h10 >> k;
        @(negedge mclk);
        {rx_valid, object_write_call, object_read_call, object_action_call, period_tick} = '0;
    endtask : strobe

    task automatic setup(input logic [2:0] f, input logic [2:0] c, input logic s,
                         input logic [2:0] l);
        @(negedge mclk);
        trigger_function_select = f;
        comm_type = c;
        output_shape_select = s;
        trigger_line_index = l;
        cycles(4);
        changes = 0;
        width = 0;
        sent_q.delete();
    endtask : setup

    // rising edge from another board on the selected line, held high ten cycles then low ten cycles
    task automatic edge_in();
        @(negedge mclk);
        ext_lvl[trigger_line_index] = 1'b1;
        t_rise = timebase;
        cycles(10);
        ext_lvl[trigger_line_index] = 1'b0;
        cycles(10);
    endtask : edge_in

    function automatic logic [FRAME_W-1:0] frm(input logic [DATA_W-1:0] d);
        return {extended_identifier, object_id, object_length, d};
    endfunction : frm

    // hang guard
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        give_verdict();
    end

    // main sequence
    initial begin
        rows[0] = '{FUNC_OUT_RECV, COMM_RECV_UNSOL, SHAPE_PULSE, 3'h0, 3'h0, 2'h2};
        rows[1] = '{FUNC_OUT_SENT, COMM_TX_CALL, SHAPE_PULSE, 3'h3, 3'h1, 2'h2};
        rows[2] = '{FUNC_OUT_CMD, COMM_TX_CALL, SHAPE_PULSE, 3'h6, 3'h3, 2'h2};
        rows[3] = '{FUNC_OUT_CMD, COMM_TX_WAVE, SHAPE_TOGGLE, 3'h2, 3'h3, 2'h1};
        rows[4] = '{FUNC_OUT_RECV, COMM_RECV_UNSOL, SHAPE_TOGGLE, 3'h5, 3'h0, 2'h1};
        rows[5] = '{FUNC_OUT_SENT, COMM_TX_CALL, SHAPE_TOGGLE, 3'h1, 3'h1, 2'h1};
        {nrst, extended_identifier, output_shape_select, period_tick, slow, prev, rx_remote} = '0;
        {object_write_call, rx_valid, object_read_call, object_action_call} = '0;
        {trigger_function_select, comm_type, trigger_line_index, edge_skip_count} = '0;
        {timestamp_user_pattern, object_id, object_length, timebase, rx_id, ext_lvl} = '0;
        {object_write_data, err_total, check_count, changes, width, run} = '0;
        cycles(20);
        check("reset", 0, {tx_req, rq_valid, trig_oe, trig_out, config_error});
        nrst = 1'b1;
        object_id = 29'h123;
        object_length = 4'h8;
        cycles(4);
        foreach (rows[i]) begin
            setup(rows[i].func, rows[i].comm, rows[i].shape, rows[i].line);
            check("trig_oe", 7'h01 << rows[i].line, trig_oe);
            object_write_data = 64'h1122334455667700 + i;
            rx_id = object_id;
            strobe(rows[i].ev);
            cycles(12);
            check("line changes", rows[i].chg, changes);
            if (rows[i].shape == SHAPE_PULSE) check("pulse width", PULSE_CYC, width);
            if (rows[i].ev == 0) check("rq_frame", frm(object_write_data), rq_frame);
            strobe(2);
        end
        setup(FUNC_OUT_CMD, COMM_TX_CALL, SHAPE_PULSE, 3'h7);
        check("clamp", {1'b1, 7'h40}, {config_error, trig_oe});
        extended_identifier = 1'b1;
        object_id = 29'h1abcdef0;
        setup(FUNC_DISABLED, COMM_TX_CALL, SHAPE_PULSE, 3'h1);
        edge_in();
        object_write_data = 64'hfeedface01234567;
        strobe(1);
        cycles(12);
        check("plain oe", 0, trig_oe);
        check("plain count", 1, sent_q.size());
        check("plain send", frm(object_write_data), sent_q[0]);
        setup(FUNC_DISABLED, COMM_RECV_UNSOL, SHAPE_PULSE, 3'h1);
        rx_id = object_id ^ 29'h1;
        strobe(0);
        cycles(3);
        check("foreign id", 0, rq_valid);
        rx_id = object_id;
        rx_remote = 1'b1;
        strobe(0);
        cycles(3);
        check("remote frame", 0, rq_valid);
        rx_remote = 1'b0;
        strobe(0);
        cycles(3);
        check("own id", 2'h2, {rq_valid, rq_is_stamp});
        strobe(2);
        cycles(2);
        check("read clears", 0, rq_valid);
        // send on edge: empty queue resends the earlier frame, fill, drain, resend
        setup(FUNC_IN_SEND, COMM_TX_CALL, SHAPE_TOGGLE, 3'h4);
        edge_in();
        check("resend count", 1, sent_q.size());
        check("resend frame", frm(64'hfeedface01234567), sent_q[0]);
        sent_q.delete();
        n = 0;
        while (write_ready === 1'b1 && n < 20) begin
            object_write_data = 64'h100 + n;
            strobe(1);
            n++;
        end
        object_write_data = 64'hdead;
        strobe(1);
        check("queue depth", FIFO_DEPTH, n);
        check("no send yet", 0, sent_q.size());
        check("input oe", 0, trig_oe);
        repeat (16) edge_in();
        comm_type = COMM_TX_PERIOD;
        repeat (3) strobe(4);
        slow = 1'b1;
        edge_in();
        check("sends", 17, sent_q.size());
        for (int i = 0; i < 17; i++)
            check("sent frame", frm(64'h100 + (i < 16 ? i : 15)), sent_q[i]);
        timestamp_user_pattern = 32'haabbccdd;
        edge_skip_count = 16'h2;
        setup(FUNC_IN_STAMP, COMM_RECV_UNSOL, SHAPE_TOGGLE, 3'h6);
        repeat (2) edge_in();
        check("skipped", 0, rq_valid);
        edge_in();
        check("stamp frame", {2'h3, STAMP_LEN, timestamp_user_pattern, 32'h0},
              {rq_valid, rq_is_stamp, rq_frame[67:0]});
        check("stamp time", 1, (rq_stamp - t_rise) inside {[2:6]});
        strobe(2);
        edge_skip_count = 16'h0;
        edge_in();
        check("no skip", 1, rq_valid);
        give_verdict();
    end
endmodule : can_object_trigger_line_logic_bench
